// file: src/port_b_pin_values_upper.sv
`timescale 1ns/100ps
// Function
// RULE_01 - Pin 4 as output drives its latch bit; analog selection never changes it.
// RULE_02 - Pin 4 input pull-up follows global disable; analog disables pull-up and input.
// RULE_03 - Pins 5 to 7 as inputs read via port, pulled up unless disabled.
// RULE_04 - Only pins with direction bit one take part in change detection.
// RULE_05 - Low-voltage programming setting dedicates pin 5 to mode entry, nothing else.
// RULE_06 - During programming or debug, pin 6 is the external serial clock input.
// RULE_07 - During programming or debug, pin 7 is bidirectional serial data.
// RULE_08 - Programming or debug disables all other functions of pins 6 and 7.
// RULE_09 - Compare unit uses pin 3 only when its pin select setting is zero.
// RULE_10 - On pin 3, direction zero outputs compare signal, one feeds capture.
// RULE_11 - After power-on, analog-capable pins are analog or digital per default setting.
// RULE_12 - Latch register reads and writes reach the output latch, not pins.
// RULE_13 - Unimplemented register bits read as zero.
// RULE_14 - Direction one floats the driver; direction zero drives the latch value.
// RULE_15 - Watched pins compared with last port read; mismatches ORed set change flag. The code also takes the snapshot on a port write.
// RULE_16 - Mismatch keeps setting the flag; a port read ends it.
// RULE_17 - Pull-up off on output pins; all pull-ups off after power-on.
// RULE_18 - Change request raised while flag and enable set, with its priority bit.
module port_b_pin_values_upper (
    // Clock and reset.
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // Register bus.
    input  wire logic [7:0]  awaddr_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    input  wire logic [7:0]  araddr_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    // Configuration settings.
    input  wire logic        low_voltage_program_cfg_in,
    input  wire logic        compare_unit_pin_select_in,
    input  wire logic        analog_default_cfg_in,
    input  wire logic        prog_debug_enable_in,
    // Port pins 3 to 7.
    input  wire logic [7:3]  pin_in,
    output logic [7:3]       pin_out,
    output logic [7:3]       pin_oe_n_out,
    output logic [7:4]       pullup_en_out,
    output logic             analog_channel_eleven_sel_out,
    // Programming and debug link.
    input  wire logic        prog_data_in,
    input  wire logic        prog_data_drive_in,
    output logic             serial_program_clock_out,
    output logic             serial_program_data_out,
    output logic             lv_programming_entry_out,
    // Second compare unit.
    input  wire logic        compare_signal_in,
    input  wire logic        default_pin_in,
    output logic             capture_out,
    output logic             default_pin_sel_out,
    // Change interrupt request.
    output logic             port_change_irq_out,
    output logic             port_change_priority_out
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus and registers.

    reg_access_if rif ();

    axil_reg_slave u_slave (
        .mclk_in     (mclk_in),
        .srst_in     (srst_in),
        .awaddr_in   (awaddr_in),
        .awvalid_in  (awvalid_in),
        .awready_out (awready_out),
        .wdata_in    (wdata_in),
        .wstrb_in    (wstrb_in),
        .wvalid_in   (wvalid_in),
        .wready_out  (wready_out),
        .bresp_out   (bresp_out),
        .bvalid_out  (bvalid_out),
        .bready_in   (bready_in),
        .araddr_in   (araddr_in),
        .arvalid_in  (arvalid_in),
        .arready_out (arready_out),
        .rdata_out   (rdata_out),
        .rresp_out   (rresp_out),
        .rvalid_out  (rvalid_out),
        .rready_in   (rready_in),
        .rif         (rif)
    );

    logic [7:0] latch_reg;
    logic [7:0] tris_reg;
    logic [7:0] irq_main_reg;
    logic [7:0] irq_edge_pu_reg;
    logic [7:0] irq_ext_reg;
    logic [7:0] analog_cfg_reg;
    logic       analog_load_reg;
    logic       change_flag;

    // Write decode; a write to the port lands in the output latch.
    wire wr_latch    = rif.wr_stb && (rif.wr_idx == port_b_pin_values_pkg::IDX_PIN_VALUES
                       || rif.wr_idx == port_b_pin_values_pkg::IDX_OUT_LATCH); // RULE_12
    wire wr_dir      = rif.wr_stb && rif.wr_idx == port_b_pin_values_pkg::IDX_DIRECTION;
    wire wr_main     = rif.wr_stb && rif.wr_idx == port_b_pin_values_pkg::IDX_IRQ_MAIN;
    wire wr_edge_pu  = rif.wr_stb && rif.wr_idx == port_b_pin_values_pkg::IDX_IRQ_EDGE_PU;
    wire wr_ext      = rif.wr_stb && rif.wr_idx == port_b_pin_values_pkg::IDX_IRQ_EXT;
    wire wr_analog   = rif.wr_stb && rif.wr_idx == port_b_pin_values_pkg::IDX_ANALOG_CFG;
    wire port_access = (rif.wr_stb && rif.wr_idx == port_b_pin_values_pkg::IDX_PIN_VALUES)
                    || (rif.rd_stb && rif.rd_idx == port_b_pin_values_pkg::IDX_PIN_VALUES);

    // Software registers; the analog default is loaded just after reset.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            latch_reg       <= port_b_pin_values_pkg::OUT_LATCH_RST;
            tris_reg        <= port_b_pin_values_pkg::DIRECTION_RST;
            irq_main_reg    <= port_b_pin_values_pkg::IRQ_MAIN_RST;
            irq_edge_pu_reg <= port_b_pin_values_pkg::IRQ_EDGE_PU_RST; // RULE_17
            irq_ext_reg     <= port_b_pin_values_pkg::IRQ_EXT_RST;
            analog_cfg_reg  <= port_b_pin_values_pkg::ANALOG_CFG_DIG;
            analog_load_reg <= 1'b1;
        end else begin
            analog_load_reg <= 1'b0;
            if (analog_load_reg) begin
                analog_cfg_reg <= analog_default_cfg_in
                    ? port_b_pin_values_pkg::ANALOG_CFG_ANA
                    : port_b_pin_values_pkg::ANALOG_CFG_DIG; // RULE_11
            end else if (wr_analog) begin
                analog_cfg_reg <= rif.wdata & port_b_pin_values_pkg::ANALOG_CFG_MASK;
            end
            if (wr_latch) latch_reg <= rif.wdata; // RULE_12
            if (wr_dir) tris_reg <= rif.wdata;
            if (wr_main) irq_main_reg <= rif.wdata;
            if (wr_edge_pu) begin
                irq_edge_pu_reg <= rif.wdata & port_b_pin_values_pkg::IRQ_EDGE_PU_MASK;
            end
            if (wr_ext) irq_ext_reg <= rif.wdata & port_b_pin_values_pkg::IRQ_EXT_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin ownership and pin functions.

    wire       lv_cfg     = low_voltage_program_cfg_in;
    wire       dbg        = prog_debug_enable_in;
    wire       pin4_ana   = analog_cfg_reg[3:0] < port_b_pin_values_pkg::PIN4_ANALOG_LIMIT;
    wire       pu_off     = irq_edge_pu_reg[port_b_pin_values_pkg::PULLUP_DIS_BIT];
    wire       ccp_here   = ~compare_unit_pin_select_in; // RULE_09
    // Pins taken over by programming entry or the debug link.
    wire [7:4] owned      = {dbg, dbg, lv_cfg, 1'b0}; // RULE_05 RULE_08
    // Digital input enable per pin; analog pin 4 and owned pins read zero.
    wire [7:4] dig_in     = ~owned & {3'h7, ~pin4_ana}; // RULE_02
    wire [7:4] watch      = tris_reg[7:4] & dig_in; // RULE_04

    logic [7:4] drive;
    logic [7:4] value;
    logic [7:4] pull;

    // Driver, value and pull-up of pins 4 to 7; pin 7 may carry debug data.
    for (genvar g = 4; g < 8; g++) begin : g_pin
        assign drive[g] = (g == 7 && dbg) ? prog_data_drive_in
                        : (~tris_reg[g] & ~owned[g]); // RULE_14 RULE_07
        assign value[g] = (g == 7 && dbg) ? prog_data_in
                        : latch_reg[g]; // RULE_01
        assign pull[g]  = ~pu_off & tris_reg[g] & dig_in[g]; // RULE_03 RULE_17
    end

    // Pin 3 carries the compare output when the unit is routed here and its direction bit is zero.
    wire pin3_val = (ccp_here && !tris_reg[3]) ? compare_signal_in
                                               : latch_reg[3]; // RULE_10
    wire capture  = ccp_here ? (tris_reg[3] & pin_in[3])
                             : default_pin_in; // RULE_10

    // Read selection; the port shows pin levels, the latch register does not.
    wire [7:0] port_rd = {pin_in[7:4] & dig_in, pin_in[3], 3'h0}; // RULE_13
    wire [7:0] main_rd = {irq_main_reg[7:1], change_flag};
    assign rif.rdata =
        (rif.rd_idx == port_b_pin_values_pkg::IDX_PIN_VALUES)  ? port_rd :
        (rif.rd_idx == port_b_pin_values_pkg::IDX_OUT_LATCH)   ? latch_reg : // RULE_12
        (rif.rd_idx == port_b_pin_values_pkg::IDX_DIRECTION)   ? tris_reg :
        (rif.rd_idx == port_b_pin_values_pkg::IDX_IRQ_MAIN)    ? main_rd :
        (rif.rd_idx == port_b_pin_values_pkg::IDX_IRQ_EDGE_PU) ? irq_edge_pu_reg :
        (rif.rd_idx == port_b_pin_values_pkg::IDX_IRQ_EXT)     ? irq_ext_reg :
        analog_cfg_reg; // RULE_13

    ////////////////////////////////////////////////////////////////////////
    // Change detection.

    port_change_detect u_change (
        .mclk_in     (mclk_in),
        .srst_in     (srst_in),
        .pin_in      (pin_in[7:4]),
        .watch_in    (watch), // RULE_04
        .sample_in   (port_access), // RULE_16
        .flag_wr_in  (wr_main),
        .flag_val_in (rif.wdata[0]),
        .flag_out    (change_flag)
    );

    wire irq_req = change_flag & irq_main_reg[port_b_pin_values_pkg::CHANGE_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pin_out                       <= 5'h00;
            pin_oe_n_out                  <= 5'h1F;
            pullup_en_out                 <= 4'h0;
            analog_channel_eleven_sel_out <= 1'b0;
            serial_program_clock_out      <= 1'b0;
            serial_program_data_out       <= 1'b0;
            lv_programming_entry_out      <= 1'b0;
            capture_out                   <= 1'b0;
            default_pin_sel_out           <= 1'b0;
            port_change_irq_out           <= 1'b0;
            port_change_priority_out      <= 1'b0;
        end else begin
            pin_out                       <= {value, pin3_val};
            pin_oe_n_out                  <= ~{drive, ~tris_reg[3]};
            pullup_en_out                 <= pull;
            analog_channel_eleven_sel_out <= pin4_ana; // RULE_02
            serial_program_clock_out      <= dbg & pin_in[6]; // RULE_06
            serial_program_data_out       <= dbg & pin_in[7]; // RULE_07
            lv_programming_entry_out      <= lv_cfg & pin_in[5]; // RULE_05
            capture_out                   <= capture;
            default_pin_sel_out           <= ~ccp_here; // RULE_09
            port_change_irq_out           <= irq_req; // RULE_18
            port_change_priority_out      <=
                irq_edge_pu_reg[port_b_pin_values_pkg::CHANGE_PRIO_BIT]; // RULE_18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_PIN4_DRIVE: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_01
        !tris_reg[4] |=> !pin_oe_n_out[4] && pin_out[4] == $past(latch_reg[4]))
        else $error("Output pin 4 not driven from its latch bit.");

    AST_PIN4_ANALOG: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_02
        pin4_ana |=> !pullup_en_out[4] && analog_channel_eleven_sel_out)
        else $error("Analog pin 4 kept its pull-up.");

    AST_PULLUP_GLOBAL: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_03
        pu_off |=> pullup_en_out == 4'h0)
        else $error("Pull-up active while globally disabled.");

    AST_PULLUP_INPUT: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_17
        !pu_off && tris_reg[6] && !dbg |=> pullup_en_out[6])
        else $error("Input pin 6 lost its pull-up.");

    AST_PULLUP_OUTPUT: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_17
        !tris_reg[5] |=> !pullup_en_out[5])
        else $error("Output pin 5 kept its pull-up.");

    AST_OUTPUTS_IGNORED: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_04
        tris_reg[7:4] == 4'h0 && !change_flag && !wr_main |=> !change_flag)
        else $error("Output pins raised the change flag.");

    AST_LV_ENTRY_PIN5: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_05
        lv_cfg |=> pin_oe_n_out[5] && !pullup_en_out[5])
        else $error("Pin 5 kept a port function under programming entry.");

    AST_DBG_CLOCK: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_06
        dbg |=> pin_oe_n_out[6] && serial_program_clock_out == $past(pin_in[6]))
        else $error("Pin 6 not passed as serial clock during debug.");

    AST_DBG_DATA: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_07
        dbg |=> pin_oe_n_out[7] == !$past(prog_data_drive_in)
            && !pullup_en_out[7])
        else $error("Pin 7 not under debug data control.");

    AST_CCP_OUT: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_10
        ccp_here && !tris_reg[3] |=> pin_out[3] == $past(compare_signal_in)
            && !default_pin_sel_out)
        else $error("Compare signal not on pin 3.");

    AST_ANALOG_POR: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_11
        analog_load_reg |=> analog_cfg_reg == ($past(analog_default_cfg_in)
            ? port_b_pin_values_pkg::ANALOG_CFG_ANA : port_b_pin_values_pkg::ANALOG_CFG_DIG))
        else $error("Analog default not applied after reset.");

    AST_IRQ: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_18
        irq_req |=> port_change_irq_out ##1 (port_change_irq_out == $past(irq_req)))
        else $error("Change request does not follow flag and enable.");

endmodule : port_b_pin_values_upper

// file: src/port_b_pin_values_pkg.sv
package port_b_pin_values_pkg;

    // Register indices; the byte address of a register is four times its index.
    localparam logic [2:0] IDX_PIN_VALUES  = 3'h0;
    localparam logic [2:0] IDX_OUT_LATCH   = 3'h1;
    localparam logic [2:0] IDX_DIRECTION   = 3'h2;
    localparam logic [2:0] IDX_IRQ_MAIN    = 3'h3;
    localparam logic [2:0] IDX_IRQ_EDGE_PU = 3'h4;
    localparam logic [2:0] IDX_IRQ_EXT     = 3'h5;
    localparam logic [2:0] IDX_ANALOG_CFG  = 3'h6;
    localparam logic [2:0] REG_COUNT       = 3'h7;

    // Implemented bits of the mixed registers; the rest read as zero.
    localparam logic [7:0] IRQ_EDGE_PU_MASK = 8'hF5;
    localparam logic [7:0] IRQ_EXT_MASK     = 8'hDB;
    localparam logic [7:0] ANALOG_CFG_MASK  = 8'h3F;

    // Values after reset.
    localparam logic [7:0] OUT_LATCH_RST   = 8'h00;
    localparam logic [7:0] DIRECTION_RST   = 8'hFF;
    localparam logic [7:0] IRQ_MAIN_RST    = 8'h00;
    localparam logic [7:0] IRQ_EDGE_PU_RST = 8'hF5;
    localparam logic [7:0] IRQ_EXT_RST     = 8'hC0;
    localparam logic [7:0] ANALOG_CFG_DIG  = 8'h0F;
    localparam logic [7:0] ANALOG_CFG_ANA  = 8'h00;

    // Pin 4 is analog while the select field is below this value.
    localparam logic [3:0] PIN4_ANALOG_LIMIT = 4'h4;

    // Field positions.
    localparam int unsigned PULLUP_DIS_BIT  = 7;
    localparam int unsigned CHANGE_PRIO_BIT = 0;
    localparam int unsigned CHANGE_EN_BIT   = 3;

    // Bus responses.
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : port_b_pin_values_pkg

// file: src/reg_access_if.sv
`timescale 1ns/100ps
interface reg_access_if;
    logic       wr_stb;
    logic [2:0] wr_idx;
    logic [7:0] wdata;
    logic       rd_stb;
    logic [2:0] rd_idx;
    logic [7:0] rdata;

    modport bus  (output wr_stb, wr_idx, wdata, rd_stb, rd_idx,
                  input  rdata);
    modport regs (input  wr_stb, wr_idx, wdata, rd_stb, rd_idx,
                  output rdata);
endinterface : reg_access_if

// file: src/axil_reg_slave.sv
`timescale 1ns/100ps
module axil_reg_slave (
    // Clock and reset.
    input  wire logic        mclk_in,
    input  wire logic        srst_in,
    // Write channels.
    input  wire logic [7:0]  awaddr_in,
    input  wire logic        awvalid_in,
    output logic             awready_out,
    input  wire logic [31:0] wdata_in,
    input  wire logic [3:0]  wstrb_in,
    input  wire logic        wvalid_in,
    output logic             wready_out,
    output logic [1:0]       bresp_out,
    output logic             bvalid_out,
    input  wire logic        bready_in,
    // Read channels.
    input  wire logic [7:0]  araddr_in,
    input  wire logic        arvalid_in,
    output logic             arready_out,
    output logic [31:0]      rdata_out,
    output logic [1:0]       rresp_out,
    output logic             rvalid_out,
    input  wire logic        rready_in,
    // Register side.
    reg_access_if.bus        rif
);

    // An address hits a register when aligned and below the register count.
    function automatic logic mapped(input logic [7:0] a);
        return (a[7:5] == 3'h0) && (a[1:0] == 2'h0)
            && (a[4:2] < port_b_pin_values_pkg::REG_COUNT);
    endfunction : mapped

    logic [7:0] awaddr_reg;
    logic [7:0] wdata_reg;
    logic       wstrb0_reg;
    logic [7:0] araddr_reg;
    logic       rd_pend_reg;

    // A ready that is low means its channel item is held here.
    wire aw_take = awvalid_in & awready_out;
    wire w_take  = wvalid_in & wready_out;
    wire ar_take = arvalid_in & arready_out;
    wire fire    = ~awready_out & ~wready_out & ~bvalid_out;
    wire b_done  = bvalid_out & bready_in;
    wire r_done  = rvalid_out & rready_in;

    // Only the low byte lane carries register data.
    assign rif.wr_stb = fire & mapped(awaddr_reg) & wstrb0_reg;
    assign rif.wr_idx = awaddr_reg[4:2];
    assign rif.wdata  = wdata_reg;
    assign rif.rd_stb = rd_pend_reg & mapped(araddr_reg);
    assign rif.rd_idx = araddr_reg[4:2];

    // Write path: both items held, then one response.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            awready_out <= 1'b1;
            wready_out  <= 1'b1;
            bvalid_out  <= 1'b0;
            bresp_out   <= port_b_pin_values_pkg::RESP_OKAY;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 8'h00;
            wstrb0_reg  <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_reg  <= awaddr_in;
                awready_out <= 1'b0;
            end
            if (w_take) begin
                wdata_reg  <= wdata_in[7:0];
                wstrb0_reg <= wstrb_in[0];
                wready_out <= 1'b0;
            end
            if (fire) begin
                bvalid_out <= 1'b1;
                bresp_out  <= mapped(awaddr_reg) ? port_b_pin_values_pkg::RESP_OKAY
                                                 : port_b_pin_values_pkg::RESP_SLVERR;
            end else if (b_done) begin
                bvalid_out  <= 1'b0;
                awready_out <= 1'b1;
                wready_out  <= 1'b1;
            end
        end
    end

    // Read path: the register is sampled one cycle after the address.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            arready_out <= 1'b1;
            rd_pend_reg <= 1'b0;
            araddr_reg  <= 8'h00;
            rvalid_out  <= 1'b0;
            rdata_out   <= 32'h0000_0000;
            rresp_out   <= port_b_pin_values_pkg::RESP_OKAY;
        end else begin
            rd_pend_reg <= ar_take;
            if (ar_take) begin
                araddr_reg  <= araddr_in;
                arready_out <= 1'b0;
            end
            if (rd_pend_reg) begin
                rvalid_out <= 1'b1;
                rdata_out  <= mapped(araddr_reg) ? {24'h00_0000, rif.rdata}
                                                 : 32'h0000_0000;
                rresp_out  <= mapped(araddr_reg) ? port_b_pin_values_pkg::RESP_OKAY
                                                 : port_b_pin_values_pkg::RESP_SLVERR;
            end else if (r_done) begin
                rvalid_out  <= 1'b0;
                arready_out <= 1'b1;
            end
        end
    end

    // A response stays offered until the master takes it.
    AST_BVALID_HOLD: assert property (@(posedge mclk_in) disable iff (srst_in)
        bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
        else $error("Write response dropped before it was taken.");

endmodule : axil_reg_slave

// file: src/port_change_detect.sv
`timescale 1ns/100ps
module port_change_detect (
    // Clock and reset.
    input  wire logic       mclk_in,
    input  wire logic       srst_in,
    // Pin levels and the pins that take part.
    input  wire logic [3:0] pin_in,
    input  wire logic [3:0] watch_in,
    // Port access, and software write of the flag.
    input  wire logic       sample_in,
    input  wire logic       flag_wr_in,
    input  wire logic       flag_val_in,
    // Change flag.
    output logic            flag_out
);

    logic [3:0] snap_reg;
    logic       flag_next;

    // Mismatches of the watched pins against the last port read or write are ORed.
    wire mismatch = |((pin_in ^ snap_reg) & watch_in); // RULE_15

    // A mismatch sets the flag even in the cycle software clears it.
    assign flag_next = mismatch | (flag_wr_in ? flag_val_in : flag_out); // RULE_16

    // A port access takes a new snapshot, ending the mismatch.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            snap_reg <= 4'h0;
            flag_out <= 1'b0;
        end else begin
            if (sample_in) begin
                snap_reg <= pin_in; // RULE_16
            end
            flag_out <= flag_next;
        end
    end

    AST_FLAG_SET: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_15
        mismatch |=> flag_out)
        else $error("Watched pin mismatch did not set the change flag.");

    AST_FLAG_STICKY: assert property (@(posedge mclk_in) disable iff (srst_in) // RULE_16
        flag_out && !flag_wr_in |=> flag_out [*1] ##0 $past(flag_out))
        else $error("Change flag cleared without a software write.");

endmodule : port_change_detect

// file: verification/port_b_pin_values_pin_model.sv
`timescale 1ns/100ps
module port_b_pin_values_pin_model (
    // Clock and device side.
    input  wire logic       mclk_in,
    input  wire logic [7:3] pin_out_in,
    input  wire logic [7:3] pin_oe_n_in,
    input  wire logic [7:4] pullup_en_in,
    // External drive and resolved level.
    input  wire logic [7:3] ext_val_in,
    input  wire logic [7:3] ext_en_in,
    output logic [7:3]      level_out
);
    logic [7:3] float_reg = 5'h0A;
    wire  [7:3] pull_on   = {pullup_en_in, 1'b0};
    // A line nobody drives toggles, so no stale level survives.
    always_ff @(posedge mclk_in) float_reg <= ~float_reg;
    // Device driver wins, then the external tool, then the pull-up.
    always_comb begin
        for (int i = 3; i < 8; i++) begin
            if (!pin_oe_n_in[i]) level_out[i] = pin_out_in[i];
            else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
            else if (pull_on[i]) level_out[i] = 1'b1;
            else level_out[i] = float_reg[i];
        end
    end
endmodule : port_b_pin_values_pin_model

// file: verification/test_port_b_pin_values_upper.sv
`timescale 1ns/100ps
module test_port_b_pin_values_upper;
    logic mclk_in, srst_in, awvalid_in, wvalid_in, bready_in, arvalid_in;
    logic rready_in, low_voltage_program_cfg_in, compare_unit_pin_select_in;
    logic analog_default_cfg_in, prog_debug_enable_in, prog_data_in;
    logic prog_data_drive_in, compare_signal_in, default_pin_in;
    logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
    logic analog_channel_eleven_sel_out, serial_program_clock_out;
    logic serial_program_data_out, lv_programming_entry_out, capture_out;
    logic default_pin_sel_out, port_change_irq_out, port_change_priority_out;
    logic [7:0]  awaddr_in, araddr_in;
    logic [31:0] wdata_in, rdata_out;
    logic [3:0]  wstrb_in;
    logic [1:0]  bresp_out, rresp_out;
    logic [7:3]  pin_in, pin_out, pin_oe_n_out, ext_val, ext_en;
    logic [7:4]  pullup_en_out;
    int          fail_count = 0;
    int          checked = 0;
    port_b_pin_values_upper i_dut (.*);
    port_b_pin_values_pin_model i_pins (.mclk_in, .pin_out_in(pin_out),
        .pin_oe_n_in(pin_oe_n_out), .pullup_en_in(pullup_en_out),
        .ext_val_in(ext_val), .ext_en_in(ext_en), .level_out(pin_in));
    ////////////////////////////////////////////////////////////////////////
    // Comparison, bus access and verdict tasks.
    task chk(input logic [9:0] s, input logic [9:0] e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task settle;
        repeat (3) @(posedge mclk_in);
    endtask : settle
    task pins(input logic [7:3] v);
        ext_val <= v;
        settle();
    endtask : pins
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        awaddr_in <= a;
        wdata_in  <= {24'h00_0000, d};
        {awvalid_in, wvalid_in, bready_in} <= 3'h7;
        do begin
            @(posedge mclk_in);
            if (awready_out) awvalid_in <= 1'b0;
            if (wready_out) wvalid_in <= 1'b0;
        end while (bvalid_out !== 1'b1);
        bready_in <= 1'b0;
    endtask : wr
    task rc(input logic [7:0] a, input logic [7:0] e,
            input logic [1:0] r = port_b_pin_values_pkg::RESP_OKAY);
        @(posedge mclk_in);
        araddr_in <= a;
        {arvalid_in, rready_in} <= 2'h3;
        do begin
            @(posedge mclk_in);
            if (arready_out) arvalid_in <= 1'b0;
        end while (rvalid_out !== 1'b1);
        rready_in <= 1'b0;
        chk({rresp_out, rdata_out[7:0]}, {r, e});
    endtask : rc
    task report_and_stop;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and the test sequence.
    initial forever #5 mclk_in = ~mclk_in;
    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {mclk_in, awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in,
         low_voltage_program_cfg_in, compare_unit_pin_select_in, awaddr_in,
         analog_default_cfg_in, prog_debug_enable_in, prog_data_in, araddr_in,
         prog_data_drive_in, default_pin_in, wdata_in, ext_val} = '0;
        {srst_in, compare_signal_in, wstrb_in, ext_en} = 11'h7FF;
        repeat (4) @(posedge mclk_in);
        srst_in <= 1'b0;
        rc(8'h08, 8'hFF);
        rc(8'h10, 8'hF5);
        rc(8'h18, 8'h0F);
        rc(8'h1C, 8'h00, port_b_pin_values_pkg::RESP_SLVERR);
        chk(pullup_en_out, 4'h0);
        wr(8'h14, 8'hFF);
        rc(8'h14, 8'hDB);
        wr(8'h18, 8'hFF);
        rc(8'h18, 8'h3F);
        $display("test 1 done");
        wr(8'h04, 8'hA0);
        wr(8'h08, 8'h07);
        settle();
        chk(pin_out, 5'h15);
        chk(pin_oe_n_out, 5'h00);
        chk(default_pin_sel_out, 1'b0);
        chk(analog_channel_eleven_sel_out, 1'b0);
        wr(8'h08, 8'hFF);
        wr(8'h10, 8'h75);
        settle();
        chk(pullup_en_out, 4'hF);
        chk(port_change_priority_out, 1'b1);
        rc(8'h04, 8'hA0);
        wr(8'h08, 8'hEF);
        settle();
        chk(pullup_en_out, 4'hE);
        wr(8'h08, 8'hFF);
        $display("test 2 done");
        rc(8'h00, 8'h00);
        wr(8'h0C, 8'h08);
        pins(5'h04);
        rc(8'h0C, 8'h09);
        chk(port_change_irq_out, 1'b1);
        rc(8'h00, 8'h20);
        wr(8'h0C, 8'h08);
        rc(8'h0C, 8'h08);
        $display("test 3 done");
        prog_debug_enable_in <= 1'b1;
        pins(5'h0C);
        chk(serial_program_clock_out, 1'b1);
        chk(serial_program_data_out, 1'b0);
        chk(capture_out, 1'b0);
        chk(pullup_en_out, 4'h3);
        rc(8'h00, 8'h20);
        low_voltage_program_cfg_in <= 1'b1;
        settle();
        chk(lv_programming_entry_out, 1'b1);
        rc(8'h00, 8'h00);
        $display("test 4 done");
        report_and_stop();
    end
endmodule : test_port_b_pin_values_upper
